//--- verilog/pllsr_regs.sv
// status registers and indirect oscillator subsystem registers of the synthesizer
`timescale 1ns/1ps
module pllsr_regs (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register access from the serial port decoder
  input  wire logic [5:0]  regAddr,
  input  wire logic [23:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [23:0] regRdData,
  output logic             regRdValid,
  // state reported by the analog side
  input  wire logic [7:0]  calSwitchSetting,
  input  wire logic        calBusy,
  input  wire logic [18:0] phaseErrMag,
  input  wire logic        phaseErrNeg,
  input  wire logic        generalPurposeOutputState,
  input  wire logic        lockDetected,
  // subsystem controls
  output logic             calVoltageSelect,
  output logic      [7:0]  subbandSelect,
  output logic             subsystemOn,
  output logic             oscOn,
  output logic             feedbackBufOn,
  output logic             outDividerOn,
  output logic             outStageOn,
  output logic      [8:0]  enableWord
);

  ////////////////////////////////////////////////////////////////////////////
  // indirect write decode helpers

  // true when a write to 0x05 targets the given oscillator subsystem register
  function automatic logic subHit(
    input logic        wrEn,
    input logic [5:0]  addr,
    input logic [23:0] data,
    input logic [3:0]  target
  );
    logic [2:0] id;
    logic [3:0] ra;
    id = data[pllsr_pkg::SUB_ID_LSB +: pllsr_pkg::SUB_ID_W];
    ra = data[pllsr_pkg::SUB_ADDR_LSB +: pllsr_pkg::SUB_ADDR_W];
    return wrEn
           && (addr == pllsr_pkg::ADDR_SUB_WR)
           && (id == pllsr_pkg::OSC_SUB_ID)
           && (ra == target);
  endfunction : subHit

  // data field of an indirect write; bits above it are ignored
  function automatic logic [8:0] subPayload(
    input logic [23:0] data
  );
    return data[pllsr_pkg::SUB_DATA_LSB +: pllsr_pkg::SUB_DATA_W];
  endfunction : subPayload

  // every block below the master enable also needs the master bit set
  function automatic logic gatedOn(
    input logic [8:0]  en,
    input int unsigned pos
  );
    return en[pllsr_pkg::EN_MASTER_BIT] & en[pos];
  endfunction : gatedOn

  ////////////////////////////////////////////////////////////////////////////
  // read decode and word packing helpers

  // a read strobe aimed at one main register address
  function automatic logic rdHit(
    input logic       rdEn,
    input logic [5:0] addr,
    input logic [5:0] target
  );
    return rdEn && (addr == target);
  endfunction : rdHit

  // read word of the tuning status register
  function automatic logic [23:0] tuneWord(
    input logic       busy,
    input logic [7:0] sw
  );
    logic [23:0] w;
    w = '0;
    w[7:0] = sw;
    w[pllsr_pkg::TUNE_BUSY_BIT] = busy;
    return w;
  endfunction : tuneWord

  // read word of the error register, sign above the magnitude
  function automatic logic [23:0] errWord(
    input logic        neg,
    input logic [18:0] mag
  );
    logic [23:0] w;
    w = '0;
    w[18:0] = mag;
    w[pllsr_pkg::ERR_SIGN_BIT] = neg;
    return w;
  endfunction : errWord

  // read word of the output and lock register
  function automatic logic [23:0] outLockWord(
    input logic general_purpose_output_state,
    input logic lock
  );
    logic [23:0] w;
    w = '0;
    w[pllsr_pkg::OL_GPO_BIT]  = general_purpose_output_state;
    w[pllsr_pkg::OL_LOCK_BIT] = lock;
    return w;
  endfunction : outLockWord

  // fixed self-test pattern, zero extended to the bus width
  function automatic logic [23:0] selfTestWord();
    logic [23:0] w;
    w = '0;
    w[16:0] = pllsr_pkg::SELF_TEST_VAL;
    return w;
  endfunction : selfTestWord

  ////////////////////////////////////////////////////////////////////////////
  // tuning status capture
  logic [7:0] switch_r, switch_nxt;
  logic       busy_r,   busy_nxt;

  // the field is only trusted by the host while busy is low, so no hold logic
  always_comb begin
    switch_nxt = calSwitchSetting;
    busy_nxt   = calBusy;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      switch_r <= pllsr_pkg::RST_SWITCH;
      busy_r   <= 1'b0;
    end else begin
      switch_r <= switch_nxt;
      busy_r   <= busy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error status capture
  logic [18:0] errMag_r, errMag_nxt;
  logic        errNeg_r, errNeg_nxt;

  // sign and magnitude share one edge so a read never mixes two samples
  always_comb begin
    errMag_nxt = phaseErrMag;
    errNeg_nxt = phaseErrNeg;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      errMag_r <= pllsr_pkg::RST_ERR_MAG;
      errNeg_r <= 1'b0;
    end else begin
      errMag_r <= errMag_nxt;
      errNeg_r <= errNeg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output and lock status capture
  logic gpo_r,  gpo_nxt;
  logic lock_r, lock_nxt;

  // both bits follow their pins with one cycle of capture delay
  always_comb begin
    gpo_nxt  = generalPurposeOutputState;
    lock_nxt = lockDetected;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpo_r  <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      gpo_r  <= gpo_nxt;
      lock_r <= lock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect write decode
  logic       hitTune;
  logic       hitEnables;
  logic [8:0] subData;

  // only the oscillator id with register 0 or 1 is taken; other writes fall away
  always_comb begin
    hitTune    = subHit(regWrEn, regAddr, regWrData, pllsr_pkg::SUB_TUNING);
    hitEnables = subHit(regWrEn, regAddr, regWrData, pllsr_pkg::SUB_ENABLES);
    subData    = subPayload(regWrData);
  end

  ////////////////////////////////////////////////////////////////////////////
  // subsystem tuning register
  logic [8:0] tuning_r, tuning_nxt;

  // a manual subband write is not reflected in the status field
  always_comb begin
    tuning_nxt = tuning_r;
    if (hitTune) begin
      tuning_nxt = subData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tuning_r <= pllsr_pkg::RST_TUNING;
    end else begin
      tuning_r <= tuning_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // subsystem enable register
  logic [8:0] enables_r, enables_nxt;

  // reserved bits are stored as written; the host keeps them at their defaults
  always_comb begin
    enables_nxt = enables_r;
    if (hitEnables) begin
      enables_nxt = subData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enables_r <= pllsr_pkg::RST_ENABLES;
    end else begin
      enables_r <= enables_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tuning controls
  logic       calSel_nxt;
  logic [7:0] subband_nxt;

  // registered from the next value so the pins follow a write at the same edge
  always_comb begin
    calSel_nxt  = tuning_nxt[pllsr_pkg::TUN_CAL_BIT];
    subband_nxt = tuning_nxt[pllsr_pkg::TUN_SUB_LSB +: 8];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      calVoltageSelect <= pllsr_pkg::RST_TUNING[pllsr_pkg::TUN_CAL_BIT];
      subbandSelect    <= pllsr_pkg::RST_TUNING[pllsr_pkg::TUN_SUB_LSB +: 8];
    end else begin
      calVoltageSelect <= calSel_nxt;
      subbandSelect    <= subband_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable controls; the master bit gates every block below it
  logic       sysOn_nxt;
  logic       oscOn_nxt;
  logic       fbOn_nxt;
  logic       divOn_nxt;
  logic       stgOn_nxt;
  logic [8:0] enWord_nxt;

  always_comb begin
    sysOn_nxt  = enables_nxt[pllsr_pkg::EN_MASTER_BIT];
    oscOn_nxt  = gatedOn(enables_nxt, pllsr_pkg::EN_OSC_BIT);
    fbOn_nxt   = gatedOn(enables_nxt, pllsr_pkg::EN_FBBUF_BIT);
    divOn_nxt  = gatedOn(enables_nxt, pllsr_pkg::EN_OUTDIV_BIT);
    // output stage needs both its own enable and the output master enable
    stgOn_nxt  = divOn_nxt & enables_nxt[pllsr_pkg::EN_OUTSTG_BIT];
    enWord_nxt = enables_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      subsystemOn   <= 1'b1;
      oscOn         <= 1'b1;
      feedbackBufOn <= 1'b1;
      outDividerOn  <= 1'b1;
      outStageOn    <= 1'b1;
      enableWord    <= pllsr_pkg::RST_ENABLES;
    end else begin
      subsystemOn   <= sysOn_nxt;
      oscOn         <= oscOn_nxt;
      feedbackBufOn <= fbOn_nxt;
      outDividerOn  <= divOn_nxt;
      outStageOn    <= stgOn_nxt;
      enableWord    <= enWord_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; subsystem registers are write-only and read as zero
  logic [23:0] rdData_nxt;
  logic        rdValid_nxt;

  // one strobe per register keeps the read mux a plain priority chain
  logic hitRdTune;
  logic hitRdErr;
  logic hitRdOutLock;
  logic hitRdSelf;

  always_comb begin
    hitRdTune    = rdHit(regRdEn, regAddr, pllsr_pkg::ADDR_TUNE_ST);
    hitRdErr     = rdHit(regRdEn, regAddr, pllsr_pkg::ADDR_ERR);
    hitRdOutLock = rdHit(regRdEn, regAddr, pllsr_pkg::ADDR_OUTLOCK);
    hitRdSelf    = rdHit(regRdEn, regAddr, pllsr_pkg::ADDR_SELFTST);
  end

  // data returns to zero outside a read so a stale word never looks fresh
  always_comb begin
    rdData_nxt  = '0;
    rdValid_nxt = regRdEn;
    if (hitRdTune) begin
      rdData_nxt = tuneWord(busy_r, switch_r);
    end else if (hitRdErr) begin
      rdData_nxt = errWord(errNeg_r, errMag_r);
    end else if (hitRdOutLock) begin
      rdData_nxt = outLockWord(gpo_r, lock_r);
    end else if (hitRdSelf) begin
      rdData_nxt = selfTestWord();
    end else begin
      rdData_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData  <= 24'h000000;
      regRdValid <= 1'b0;
    end else begin
      regRdData  <= rdData_nxt;
      regRdValid <= rdValid_nxt;
    end
  end

endmodule : pllsr_regs

//--- inc/pllsr_pkg.sv
// constants for the synthesizer status and oscillator subsystem register bank
// Overview of operation
// - tuning status is read-only; bits 7:0 give the calibrated switch setting
// - switch code zero is highest frequency band, 255 the lowest
// - unused upper switch bits carry no meaning; host ignores them
// - bit 8 reads one while calibration searches, zero otherwise; resets zero
// - error register read-only: magnitude in bits 18:0, sign in bit 19
// - output and lock register read-only: bit 0 output state, bit 1 lock
// - self-test register read-only, 17-bit value reading 4697 after reset
// - subsystem registers reached only through writes to main register 0x05
// - subsystem tuning bit 0 redirects tune voltage to calibration voltage, default 0
// - tuning bits 8:1 select subband, zero max frequency, default 16
// - enable bit 0 master turns all off, bit 1 enables oscillators, default one
// - enable bit 2 gates the feedback divider buffer, default one
// - enable bit 3 output stage and divider, bit 5 output stage, default one
package pllsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // main register map
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned DATA_W       = 24;
  localparam logic [5:0]  ADDR_SUB_WR  = 6'h05;
  localparam logic [5:0]  ADDR_TUNE_ST = 6'h10;
  localparam logic [5:0]  ADDR_ERR     = 6'h11;
  localparam logic [5:0]  ADDR_OUTLOCK = 6'h12;
  localparam logic [5:0]  ADDR_SELFTST = 6'h13;

  ////////////////////////////////////////////////////////////////////////////
  // status field positions and reset values
  localparam int unsigned TUNE_BUSY_BIT = 8;
  localparam int unsigned ERR_SIGN_BIT  = 19;
  localparam int unsigned OL_GPO_BIT    = 0;
  localparam int unsigned OL_LOCK_BIT   = 1;
  localparam logic [7:0]  RST_SWITCH    = 8'h20;
  localparam logic [18:0] RST_ERR_MAG   = 19'h7ffff;
  localparam logic [16:0] SELF_TEST_VAL = 17'h01259;

  ////////////////////////////////////////////////////////////////////////////
  // indirect write field layout in main register 0x05
  localparam int unsigned SUB_ID_LSB   = 0;
  localparam int unsigned SUB_ID_W     = 3;
  localparam int unsigned SUB_ADDR_LSB = 3;
  localparam int unsigned SUB_ADDR_W   = 4;
  localparam int unsigned SUB_DATA_LSB = 7;
  localparam int unsigned SUB_DATA_W   = 9;
  localparam logic [2:0]  OSC_SUB_ID   = 3'h0;
  localparam logic [3:0]  SUB_TUNING   = 4'h0;
  localparam logic [3:0]  SUB_ENABLES  = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // subsystem register fields and defaults
  localparam int unsigned TUN_CAL_BIT    = 0;
  localparam int unsigned TUN_SUB_LSB    = 1;
  localparam logic [8:0]  RST_TUNING     = 9'h020;
  localparam int unsigned EN_MASTER_BIT  = 0;
  localparam int unsigned EN_OSC_BIT     = 1;
  localparam int unsigned EN_FBBUF_BIT   = 2;
  localparam int unsigned EN_OUTDIV_BIT  = 3;
  localparam int unsigned EN_OUTSTG_BIT  = 5;
  localparam logic [8:0]  RST_ENABLES    = 9'h1ff;

endpackage : pllsr_pkg

//--- verification/pllsr_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module pllsr_assertions (
  // bus and clock
  input wire logic sys_clk, rst, regWrEn, regRdEn, regRdValid,
  input wire logic [5:0] regAddr,
  input wire logic [23:0] regWrData, regRdData,
  // status and controls
  input wire logic [7:0] calSwitchSetting, subbandSelect,
  input wire logic calBusy, calVoltageSelect, oscOn, outStageOn,
  input wire logic [8:0] enableWord
);
  // status reads right after reset still return reset captures, so skip them
  logic [1:0] up_r;
  always_ff @(posedge sys_clk or posedge rst) if (rst) up_r <= 2'h0; else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_TUNE: assert property (regRdEn && regAddr == 6'h10 && |up_r |=> regRdValid &&
    regRdData == {15'h0, $past(calBusy, 2), $past(calSwitchSetting, 2)}) else $error("tune status read");
  AST_SELF: assert property (regRdEn && regAddr == 6'h13 |=> regRdData == 24'h001259)
    else $error("self test read");
  AST_IND: assert property (regRdEn && regAddr == 6'h05 |=> regRdValid && regRdData == 24'h0)
    else $error("indirect register readable");
  AST_QUIET: assert property (!regRdEn |=> !regRdValid && regRdData == 24'h0)
    else $error("read answer without request");
  AST_TUNWR: assert property (regWrEn && regAddr == 6'h05 && regWrData[6:0] == 7'h00 |=>
    calVoltageSelect == $past(regWrData[7]) && subbandSelect == $past(regWrData[15:8])) else $error("tuning write");
  AST_ENWR: assert property (regWrEn && regAddr == 6'h05 && regWrData[6:0] == 7'h08 |=>
    enableWord == $past(regWrData[15:7])) else $error("enable write");
  AST_DERIV: assert property (oscOn == (enableWord[0] & enableWord[1]) &&
    outStageOn == (enableWord[0] & enableWord[3] & enableWord[5])) else $error("derived enables");
  AST_IGN: assert property (regWrEn && regAddr != 6'h05 |=> $stable(enableWord) && $stable(subbandSelect))
    else $error("direct write changed subsystem");
endmodule : pllsr_assertions
bind pllsr_regs pllsr_assertions pllsr_assertions_i (.sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdValid(regRdValid), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .calSwitchSetting(calSwitchSetting), .subbandSelect(subbandSelect), .calBusy(calBusy),
  .calVoltageSelect(calVoltageSelect), .oscOn(oscOn), .outStageOn(outStageOn), .enableWord(enableWord));

//--- verification/pllsr_host_model.sv
// host side model issuing register accesses
`timescale 1ns/1ps
module pllsr_host_model (
  // clock and answer
  input wire logic sys_clk, regRdValid,
  input wire logic [23:0] regRdData,
  // requests
  output logic [5:0] regAddr,
  output logic [23:0] regWrData,
  output logic regWrEn, regRdEn
);
  initial {regAddr, regWrData, regWrEn, regRdEn} = {6'h3f, 24'h0, 2'b00};
  // idle lines show inverted data so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge sys_clk); {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
    @(posedge sys_clk); {regAddr, regWrData, regWrEn} <= {~a, ~d, 1'b0};
  endtask : wr
  task automatic sub(input logic [2:0] id, input logic [3:0] ra, input logic [8:0] d);
    wr(6'h05, {8'h00, d, ra, id});
  endtask : sub
  task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
    @(posedge sys_clk); {regAddr, regRdEn} <= {a, 1'b1};
    @(posedge sys_clk); {regAddr, regRdEn} <= {~a, 1'b0};
    @(negedge sys_clk); {v, d} = {regRdValid, regRdData};
  endtask : rd
endmodule : pllsr_host_model

//--- verification/testbench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nErrors++; $display("[FAIL] %0t got %h", $time, a); end end
module testbench;
  logic sys_clk = 1'b0, rst = 1'b1, calBusy = 1'b0, errNeg = 1'b0, general_purpose_output_state = 1'b0, lock = 1'b0, v;
  logic [7:0] sw = 8'h00, subbandSelect;
  logic [18:0] mag = 19'h0;
  logic [5:0] regAddr;
  logic [23:0] regWrData, regRdData, d;
  logic regWrEn, regRdEn, regRdValid, calVoltageSelect, subsystemOn, oscOn, fbOn, divOn, outStageOn;
  logic [8:0] enableWord;
  int nErrors = 0, checksDone = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  pllsr_regs pllsr_regs_i (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .calSwitchSetting(sw), .calBusy(calBusy), .phaseErrMag(mag), .phaseErrNeg(errNeg),
    .generalPurposeOutputState(general_purpose_output_state), .lockDetected(lock), .calVoltageSelect(calVoltageSelect),
    .subbandSelect(subbandSelect), .subsystemOn(subsystemOn), .oscOn(oscOn), .feedbackBufOn(fbOn),
    .outDividerOn(divOn), .outStageOn(outStageOn), .enableWord(enableWord));
  pllsr_host_model pllsr_host_model_i (.sys_clk(sys_clk), .regRdValid(regRdValid), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
  task automatic end_sim();
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      nErrors++;
      end_sim();
    end
  end
  task automatic rchk(input logic [5:0] a, input logic [23:0] e);
    pllsr_host_model_i.rd(a, d, v);
    `CHK({v, d}, {1'b1, e})
  endtask : rchk
  task automatic t_status();
    @(posedge sys_clk); {sw, calBusy, mag, errNeg, general_purpose_output_state, lock} <= {8'hff, 1'b1, 19'h40001, 3'b110};
    rchk(6'h10, 24'h0001ff);
    rchk(6'h11, 24'h0c0001);
    rchk(6'h12, 24'h000001);
    @(posedge sys_clk); {sw, calBusy, errNeg, general_purpose_output_state, lock} <= {8'h00, 4'b0001};
    rchk(6'h10, 24'h000000);
    rchk(6'h11, 24'h040001);
    rchk(6'h12, 24'h000002);
    rchk(6'h13, 24'h001259);
    rchk(6'h05, 24'h000000);
  endtask : t_status
  task automatic t_sub();
    `CHK({subbandSelect, calVoltageSelect, enableWord, subsystemOn, oscOn, fbOn, divOn, outStageOn}, 23'h083fff)
    pllsr_host_model_i.sub(3'h0, 4'h1, 9'h1df);
    @(negedge sys_clk);
    `CHK({enableWord, outStageOn, divOn, oscOn}, {9'h1df, 3'b011})
    pllsr_host_model_i.sub(3'h0, 4'h1, 9'h1d3);
    @(negedge sys_clk);
    `CHK({fbOn, divOn, oscOn}, 3'b001)
    pllsr_host_model_i.sub(3'h0, 4'h1, 9'h1fe);
    @(negedge sys_clk);
    `CHK({subsystemOn, oscOn, fbOn, divOn, outStageOn}, 5'h00)
    pllsr_host_model_i.sub(3'h0, 4'h0, 9'h1ff);
    @(negedge sys_clk);
    `CHK({subbandSelect, calVoltageSelect}, 9'h1ff)
    pllsr_host_model_i.sub(3'h1, 4'h0, 9'h000);
    pllsr_host_model_i.wr(6'h00, 24'h000000);
    @(negedge sys_clk);
    `CHK({subbandSelect, calVoltageSelect}, 9'h1ff)
  endtask : t_sub
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    t_sub();
    t_status();
    end_sim();
  end
endmodule : testbench
